/* File: src/tcsr_cfg_if.sv */
// interface: live engine settings passed from the register bank to
// the task snapshot stage
// assumes: one clock domain, pure wires
interface tcsr_cfg_if;
    logic [4:0]  lineGap;
    logic [5:0]  spacing;
    logic [23:0] forePix;
    logic [23:0] backPix;
    logic [31:0] glyphBase;

    modport src (output lineGap, spacing, forePix, backPix, glyphBase);
    modport snk (input  lineGap, spacing, forePix, backPix, glyphBase);
endinterface

/* File: src/tcsr_color_map.sv */
// colour mapper: packs one 8:8:8 colour into the pixel of the
// selected depth, right aligned, upper bits zero
// assumes: depth code 2'h3 behaves as 24-bit
module tcsr_color_map
    import tcsr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  red,
    input  wire logic [7:0]  green,
    input  wire logic [7:0]  blue,
    input  wire logic [1:0]  depth,
    output      logic [23:0] pix
);

    // ------------------------------------------------------------
    // packing
    // ------------------------------------------------------------
    always_comb begin
        case (depth)
            // [RQ5] red 7:5, green 7:5, blue 7:6
            DEPTH_8:  pix = {16'h0000, red[7:5], green[7:5], blue[7:6]};
            // [RQ6] red 7:3, green 7:2, blue 7:3
            DEPTH_16: pix = {8'h00, red[7:3], green[7:2], blue[7:3]};
            // [RQ7] every component bit kept
            default:  pix = {red, green, blue};
        endcase
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_map8;
        depth == DEPTH_8 |-> pix[7:0] == {red[7:5], green[7:5], blue[7:6]}
            && pix[23:8] == 16'h0000;
    endproperty
    a_map8: assert property (p_map8) else $error("8-bit packing wrong"); // [RQ5]

    property p_map16;
        depth == DEPTH_16 |-> pix[15:0] == {red[7:3], green[7:2], blue[7:3]};
    endproperty
    a_map16: assert property (p_map16) else $error("16-bit packing wrong"); // [RQ6]

    property p_map24;
        depth == DEPTH_24 |-> pix == {red, green, blue};
    endproperty
    a_map24: assert property (p_map24) else $error("24-bit packing wrong"); // [RQ7]

endmodule // tcsr_color_map

/* File: src/tcsr_pkg.sv */
// package: register map, field layout and reset values of the text
// colour and spacing register bank
// assumes: byte-wide registers, each on its own 32-bit APB word
package tcsr_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 8;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_LINE_GAP   = 8'hD0;
    localparam logic [IDX_W-1:0] IDX_SPACING    = 8'hD1;
    localparam logic [IDX_W-1:0] IDX_FORE_RED   = 8'hD2;
    localparam logic [IDX_W-1:0] IDX_FORE_GREEN = 8'hD3;
    localparam logic [IDX_W-1:0] IDX_FORE_BLUE  = 8'hD4;
    localparam logic [IDX_W-1:0] IDX_BACK_RED   = 8'hD5;
    localparam logic [IDX_W-1:0] IDX_BACK_GREEN = 8'hD6;
    localparam logic [IDX_W-1:0] IDX_BACK_BLUE  = 8'hD7;
    localparam logic [IDX_W-1:0] IDX_RSVD_FIRST = 8'hD8;
    localparam logic [IDX_W-1:0] IDX_RSVD_LAST  = 8'hDA;
    localparam logic [IDX_W-1:0] IDX_GLYPH_B0   = 8'hDB;
    localparam logic [IDX_W-1:0] IDX_GLYPH_B1   = 8'hDC;
    localparam logic [IDX_W-1:0] IDX_GLYPH_B2   = 8'hDD;
    localparam logic [IDX_W-1:0] IDX_GLYPH_B3   = 8'hDE;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 8'hF0;
    localparam logic [IDX_W-1:0] IDX_DEPTH      = 8'hF1;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int GAP_W       = 5;
    localparam int SPACE_W     = 6;
    localparam int BUSY_BIT    = 3;
    localparam logic [7:0] FORE_RESET    = 8'hFF;
    localparam logic [7:0] BACK_RESET    = 8'h00;
    localparam logic [7:0] PLAIN_RESET   = 8'h00;

    typedef enum logic [1:0] {
        DEPTH_8  = 2'h0,
        DEPTH_16 = 2'h1,
        DEPTH_24 = 2'h2
    } tcsr_depth_t;
    localparam logic [1:0] DEPTH_RESET = 2'h0;

endpackage

/* File: src/tcsr_regs.sv */
// text colour and spacing register bank with APB slave and task
// snapshot toward the drawing engine
// assumes: APB3 master on clk_sys, engine pulses start and done
//
// Behaviour
// [RQ1] five-bit line gap in pixels at wrap
// [RQ2] gap painted background, never enlarged
// [RQ3] six-bit inter-character spacing, 0 to 63
// [RQ4] spacing painted background, never enlarged
// [RQ5] red uses 7:5, 7:3 or 7:0
// [RQ6] green uses 7:5, 7:2 or 7:0
// [RQ7] blue uses 7:6, 7:3 or 7:0
// [RQ8] foreground for draw/text, resets to FFh
// [RQ9] background for text, resets to 00h
// [RQ10] host keeps background unequal to foreground
// [RQ11] glyph base built from four bytes
// [RQ12] glyph data fetched from programmed base
// [RQ13] host waits busy low before changing
// [RQ14] reserved bytes read zero, writes ignored
// [RQ15] line gap bits 7:5 read zero
// [RQ16] settings frozen for a whole task
module tcsr_regs
    import tcsr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output      logic [DATA_W-1:0] prdata,
    output      logic              pready,
    output      logic              pslverr,
    input  wire logic              taskStart,
    input  wire logic              taskDone,
    output      logic [4:0]        engLineGap,
    output      logic [5:0]        engSpacing,
    output      logic [23:0]       engFore,
    output      logic [23:0]       engBack,
    output      logic [31:0]       engGlyphBase,
    output      logic              engBusy
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [4:0]  lineGap_q;
    logic [7:0]  spacing_q;
    logic [7:0]  foreRed_q;
    logic [7:0]  foreGreen_q;
    logic [7:0]  foreBlue_q;
    logic [7:0]  backRed_q;
    logic [7:0]  backGreen_q;
    logic [7:0]  backBlue_q;
    logic [7:0]  glyph_q [4];
    logic [1:0]  depth_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0]  idx;
    logic        aligned;
    logic        wrEn;
    logic        rdHit;
    logic [7:0]  rdByte;

    tcsr_cfg_if cfg ();

    function automatic logic mapped(input logic [7:0] i);
        mapped = (i >= IDX_LINE_GAP && i <= IDX_GLYPH_B3)
            || i == IDX_STATUS || i == IDX_DEPTH;
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign idx     = paddr[9:2];
    assign aligned = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
    // write lands at the edge where the access phase is answered
    assign wrEn    = psel && penable && pready_q && pwrite
        && aligned && mapped(idx);

    // no wait states: ready in the first access cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !(aligned && mapped(idx));
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lineGap_q <= '0;
            spacing_q <= PLAIN_RESET;
            depth_q   <= DEPTH_RESET;
        end else if (wrEn) begin
            // [RQ15] upper gap bits dropped
            if (idx == IDX_LINE_GAP) lineGap_q <= pwdata[GAP_W-1:0];
            if (idx == IDX_SPACING)  spacing_q <= pwdata[7:0];
            if (idx == IDX_DEPTH)    depth_q   <= pwdata[1:0];
        end
    end

    // [RQ8] foreground resets to all ones
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            foreRed_q   <= FORE_RESET;
            foreGreen_q <= FORE_RESET;
            foreBlue_q  <= FORE_RESET;
        end else if (wrEn) begin
            if (idx == IDX_FORE_RED)   foreRed_q   <= pwdata[7:0];
            if (idx == IDX_FORE_GREEN) foreGreen_q <= pwdata[7:0];
            if (idx == IDX_FORE_BLUE)  foreBlue_q  <= pwdata[7:0];
        end
    end

    // [RQ9] background resets to zero
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            backRed_q   <= BACK_RESET;
            backGreen_q <= BACK_RESET;
            backBlue_q  <= BACK_RESET;
        end else if (wrEn) begin
            if (idx == IDX_BACK_RED)   backRed_q   <= pwdata[7:0];
            if (idx == IDX_BACK_GREEN) backGreen_q <= pwdata[7:0];
            if (idx == IDX_BACK_BLUE)  backBlue_q  <= pwdata[7:0];
        end
    end

    // [RQ11] one byte per glyph base register
    // bounded both ways: status and depth indices lie above
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) glyph_q[i] <= PLAIN_RESET;
        end else if (wrEn && idx >= IDX_GLYPH_B0
                && idx <= IDX_GLYPH_B3) begin
            glyph_q[2'(idx - IDX_GLYPH_B0)] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdByte = 8'h00;
        case (idx)
            // [RQ15] bits 7:5 read zero
            IDX_LINE_GAP:   rdByte = {3'h0, lineGap_q};
            IDX_SPACING:    rdByte = spacing_q;
            IDX_FORE_RED:   rdByte = foreRed_q;
            IDX_FORE_GREEN: rdByte = foreGreen_q;
            IDX_FORE_BLUE:  rdByte = foreBlue_q;
            IDX_BACK_RED:   rdByte = backRed_q;
            IDX_BACK_GREEN: rdByte = backGreen_q;
            IDX_BACK_BLUE:  rdByte = backBlue_q;
            IDX_GLYPH_B0:   rdByte = glyph_q[0];
            IDX_GLYPH_B1:   rdByte = glyph_q[1];
            IDX_GLYPH_B2:   rdByte = glyph_q[2];
            IDX_GLYPH_B3:   rdByte = glyph_q[3];
            IDX_STATUS:     rdByte = 8'(engBusy) << BUSY_BIT;
            IDX_DEPTH:      rdByte = {6'h00, depth_q};
            // [RQ14] reserved and unmapped read zero
            default:        rdByte = 8'h00;
        endcase
    end

    assign rdHit = psel && !penable && !pwrite && aligned;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prdata_q <= '0;
        end else if (rdHit) begin
            prdata_q <= {24'h000000, rdByte};
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // live settings toward the snapshot
    // ------------------------------------------------------------
    // [RQ1] gap passed in pixels
    assign cfg.lineGap   = lineGap_q;
    // [RQ3] low six bits give the spacing
    assign cfg.spacing   = spacing_q[SPACE_W-1:0];
    // [RQ11] bytes joined low to high
    assign cfg.glyphBase = {glyph_q[3], glyph_q[2], glyph_q[1], glyph_q[0]};

    tcsr_color_map u_fore (
        .clk_sys (clk_sys),
        .reset   (reset),
        .red     (foreRed_q),
        .green   (foreGreen_q),
        .blue    (foreBlue_q),
        .depth   (depth_q),
        .pix     (cfg.forePix)
    );

    tcsr_color_map u_back (
        .clk_sys (clk_sys),
        .reset   (reset),
        .red     (backRed_q),
        .green   (backGreen_q),
        .blue    (backBlue_q),
        .depth   (depth_q),
        .pix     (cfg.backPix)
    );

    // [RQ2] gap and spacing carry no enlargement; the engine fills
    // them with engBack, the same pixel it uses for text background
    // [RQ4] spacing width passed unscaled
    // [RQ12] engine fetches glyphs from engGlyphBase
    tcsr_task_latch u_latch (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .taskStart   (taskStart),
        .taskDone    (taskDone),
        .cfg         (cfg),
        .lineGap_q   (engLineGap),
        .spacing_q   (engSpacing),
        .forePix_q   (engFore),
        .backPix_q   (engBack),
        .glyphBase_q (engGlyphBase),
        .busy_q      (engBusy)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    property p_ready;
        s_setup |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access"); // [RQ14]

    property p_gap_wr;
        s_access ##0 (pwrite && idx == IDX_LINE_GAP && aligned)
            |=> lineGap_q == $past(pwdata[4:0]);
    endproperty
    a_gap_wr: assert property (p_gap_wr) else $error("gap write lost"); // [RQ1]

    property p_gap_rd;
        s_setup ##0 (!pwrite && idx == IDX_LINE_GAP && aligned)
            |=> prdata[31:5] == 27'h0;
    endproperty
    a_gap_rd: assert property (p_gap_rd) else $error("gap high bits set"); // [RQ15]

    property p_rsvd;
        s_setup ##0 (!pwrite && idx >= IDX_RSVD_FIRST
            && idx <= IDX_RSVD_LAST) |=> prdata == 32'h0 && !pslverr;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved not zero"); // [RQ14]

    property p_sp_wr;
        s_access ##0 (pwrite && idx == IDX_SPACING && aligned)
            ##2 taskStart |=> engSpacing == $past(pwdata[5:0], 3);
    endproperty
    a_sp_wr: assert property (p_sp_wr) else $error("spacing not used"); // [RQ3]

    property p_fore_rst;
        $past(reset) |-> foreRed_q == 8'hFF && foreBlue_q == 8'hFF;
    endproperty
    a_fore_rst: assert property (p_fore_rst) else $error("fore reset"); // [RQ8]

    property p_back_rst;
        $past(reset) |-> backGreen_q == 8'h00 && backRed_q == 8'h00;
    endproperty
    a_back_rst: assert property (p_back_rst) else $error("back reset"); // [RQ9]

    property p_glyph;
        taskStart |=> engGlyphBase[31:24] == $past(glyph_q[3])
            && engGlyphBase[7:0] == $past(glyph_q[0]);
    endproperty
    a_glyph: assert property (p_glyph) else $error("glyph base order"); // [RQ11]

    // writes above the glyph bytes must not reach them
    property p_glyph_keep;
        s_access ##0 (pwrite && idx > IDX_GLYPH_B3)
            |=> $stable(cfg.glyphBase);
    endproperty
    a_glyph_keep: assert property (p_glyph_keep) // [RQ11]
        else $error("glyph base clobbered");

    property p_err;
        s_setup ##0 !(aligned && mapped(idx)) |=> pslverr && pready;
    endproperty
    a_err: assert property (p_err) // [RQ14]
        else $error("refusal not flagged");

endmodule // tcsr_regs

/* File: src/tcsr_task_latch.sv */
// task snapshot: freezes the settings while a drawing or text task
// runs and tracks the busy flag
// assumes: engine pulses taskStart and taskDone for one cycle each
module tcsr_task_latch
    import tcsr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        taskStart,
    input  wire logic        taskDone,
    tcsr_cfg_if.snk          cfg,
    output      logic [4:0]  lineGap_q,
    output      logic [5:0]  spacing_q,
    output      logic [23:0] forePix_q,
    output      logic [23:0] backPix_q,
    output      logic [31:0] glyphBase_q,
    output      logic        busy_q
);

    // ------------------------------------------------------------
    // busy flag: a new start in the done cycle keeps it set
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else if (taskStart) begin
            busy_q <= 1'b1;
        end else if (taskDone) begin
            busy_q <= 1'b0;
        end
    end

    // [RQ16] sample at task start
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lineGap_q   <= '0;
            spacing_q   <= '0;
            forePix_q   <= '0;
            backPix_q   <= '0;
            glyphBase_q <= '0;
        end else if (taskStart) begin
            lineGap_q   <= cfg.lineGap;
            spacing_q   <= cfg.spacing;
            forePix_q   <= cfg.forePix;
            backPix_q   <= cfg.backPix;
            glyphBase_q <= cfg.glyphBase;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_hold;
        !taskStart |=> $stable(forePix_q) && $stable(glyphBase_q)
            && $stable(lineGap_q);
    endproperty
    a_hold: assert property (p_hold) else $error("snapshot moved mid-task"); // [RQ16]

    property p_take;
        taskStart |=> busy_q && forePix_q == $past(cfg.forePix)
            && spacing_q == $past(cfg.spacing);
    endproperty
    a_take: assert property (p_take) else $error("snapshot not taken"); // [RQ16]

endmodule // tcsr_task_latch

/* File: tb/tcsr_apb_host.sv */
// partner model: apb master standing in for the host processor
// assumes: xfer is entered just after a rising edge of clk_sys
module tcsr_apb_host
    import tcsr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              pready,
    output      logic              psel,
    output      logic              penable,
    output      logic              pwrite,
    output      logic [ADDR_W-1:0] paddr,
    output      logic [DATA_W-1:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // held until pready at an edge; keep chains the next setup
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input bit keep,
                        output bit ok);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 64);
        ok = (pready === 1'b1);
        penable <= 1'b0;
        if (!keep) begin
            // stale lines scrambled, never trusted when idle
            psel   <= 1'b0;
            paddr  <= ~a;
            pwdata <= ~d;
            @(posedge clk_sys);
        end
    endtask
endmodule // tcsr_apb_host

/* File: tb/testbench.sv */
// testbench: register access, engine snapshots, refusals, resets
// assumes: tcsr_regs and its apb timing as handed over
module testbench
    import tcsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk_sys, reset, psel, penable, pwrite;
    logic              pready, pslverr, taskStart, taskDone;
    logic              trig, s1, busyExp, engBusy;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [4:0]        engLineGap;
    logic [5:0]        engSpacing;
    logic [23:0]       engFore, engBack;
    logic [31:0]       engGlyphBase, rs;
    logic [90:0]       engSnap;
    logic [32:0]       eRd;
    logic [91:0]       eEng;
    logic [7:0]        mem [0:255];
    logic [32:0]       qRd [$];
    logic [91:0]       qEng [$];
    bit                ok;
    int                n_fail, total_checks;
    wire  [91:0]       engGot = {engLineGap, engSpacing, engFore,
                                 engBack, engGlyphBase, engBusy};

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    tcsr_regs DUT (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .taskStart    (taskStart),
        .taskDone     (taskDone),
        .engLineGap   (engLineGap),
        .engSpacing   (engSpacing),
        .engFore      (engFore),
        .engBack      (engBack),
        .engGlyphBase (engGlyphBase),
        .engBusy      (engBusy)
    );

    tcsr_apb_host u_host (
        .clk_sys (clk_sys),
        .pready  (pready),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata)
    );

    // ------------------------------------------------------------
    // expectation model
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    function automatic logic [ADDR_W-1:0] ad(logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    function automatic logic [23:0] pix(logic [7:0] r, g, b);
        case (mem[IDX_DEPTH][1:0])
            2'h0:    return {16'h0, r[7:5], g[7:5], b[7:6]};
            2'h1:    return {8'h0, r[7:3], g[7:2], b[7:3]};
            default: return {r, g, b};
        endcase
    endfunction

    function automatic bit bad(logic [ADDR_W-1:0] a);
        return a[1:0] != 2'h0 || a[11:10] != 2'h0 || !(a[9:2] inside
            {[IDX_LINE_GAP:IDX_GLYPH_B3], IDX_STATUS, IDX_DEPTH});
    endfunction

    function automatic logic [31:0] rdv(logic [7:0] i);
        if (i == IDX_LINE_GAP) return {27'h0, mem[i][4:0]};
        if (i inside {[IDX_RSVD_FIRST:IDX_RSVD_LAST]}) return 32'h0;
        if (i == IDX_STATUS) return {28'h0, busyExp, 3'h0};
        if (i == IDX_DEPTH) return {30'h0, mem[i][1:0]};
        return {24'h0, mem[i]};
    endfunction

    task automatic init_mem();
        for (int i = 0; i < 256; i++) mem[i] = PLAIN_RESET;
        for (int i = IDX_FORE_RED; i <= IDX_FORE_BLUE; i++)
            mem[i] = FORE_RESET;
        busyExp = 1'b0;
        engSnap = '0;
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d,
                       bit k);
        logic [7:0] i;
        i = a[9:2];
        if (!wr) qRd.push_back({bad(a), bad(a) ? 32'h0 : rdv(i)});
        else begin
            qRd.push_back({bad(a), 32'h0});
            if (!bad(a) && !(i inside
                {[IDX_RSVD_FIRST:IDX_RSVD_LAST], IDX_STATUS}))
                mem[i] = d[7:0];
        end
        u_host.xfer(wr, a, d, k, ok);
        if (!ok) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic rd_all();
        for (int i = IDX_LINE_GAP; i <= IDX_DEPTH; i++)
            bus(1'b0, ad(8'(i)), 32'h0, i != IDX_DEPTH);
    endtask

    // start snapshots live values; probe rechecks without a start
    task automatic pulse(bit st, bit dn, bit pr);
        if (st)
            engSnap = {mem[IDX_LINE_GAP][4:0], mem[IDX_SPACING][5:0],
                pix(mem[IDX_FORE_RED], mem[IDX_FORE_GREEN],
                    mem[IDX_FORE_BLUE]),
                pix(mem[IDX_BACK_RED], mem[IDX_BACK_GREEN],
                    mem[IDX_BACK_BLUE]),
                mem[IDX_GLYPH_B3], mem[IDX_GLYPH_B2],
                mem[IDX_GLYPH_B1], mem[IDX_GLYPH_B0]};
        busyExp = st | (busyExp & !dn);
        if (st | pr) qEng.push_back({engSnap, busyExp});
        taskStart <= st;
        taskDone  <= dn;
        trig      <= st | pr;
        @(posedge clk_sys);
        taskStart <= 1'b0;
        taskDone  <= 1'b0;
        trig      <= 1'b0;
        @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    task automatic chk_rd(logic [32:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_eng(logic [91:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    always @(posedge clk_sys) begin
        s1 <= trig;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            eRd = qRd.size() > 0 ? qRd.pop_front() : 'x;
            chk_rd(eRd, {pslverr, pwrite ? 32'h0 : prdata});
        end
    end

    always @(negedge clk_sys) begin
        if (s1 === 1'b1) begin
            eEng = qEng.size() > 0 ? qEng.pop_front() : 'x;
            chk_eng(eEng, engGot);
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rs           = 32'hE28BA9A1;
        reset        = 1'b1;
        taskStart    = 1'b0;
        taskDone     = 1'b0;
        trig         = 1'b0;
        n_fail       = 0;
        total_checks = 0;
        init_mem();
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        pulse(1'b0, 1'b0, 1'b1);
        rd_all();
        bus(1'b0, 12'h341, 32'h0, 1'b1);
        bus(1'b1, 12'h740, rnd(), 1'b0);
        for (int i = IDX_LINE_GAP; i <= IDX_STATUS; i++)
            bus(1'b1, ad(8'(i)), rnd(), 1'b1);
        bus(1'b1, ad(IDX_DEPTH), 32'h1, 1'b0);
        rd_all();
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, ad(IDX_DEPTH), 32'(k), 1'b1);
            for (int i = IDX_LINE_GAP; i <= IDX_GLYPH_B3; i++)
                bus(1'b1, ad(8'(i)), rnd(), 1'b1);
            bus(1'b1, ad(IDX_BACK_RED), {24'h0, ~mem[IDX_FORE_RED]}, 1'b1);
            bus(1'b1, ad(IDX_SPACING), rnd(), 1'b0);
            pulse(1'b1, 1'b0, 1'b0);
            bus(1'b0, ad(IDX_STATUS), 32'h0, 1'b0);
            pulse(1'b0, 1'b1, 1'b0);
            bus(1'b0, ad(IDX_STATUS), 32'h0, 1'b1);
            for (int i = IDX_LINE_GAP; i <= IDX_BACK_BLUE; i++)
                bus(1'b1, ad(8'(i)), rnd(), 1'b1);
            bus(1'b1, ad(IDX_GLYPH_B0), rnd(), 1'b0);
            pulse(1'b0, 1'b0, 1'b1);
        end
        // start and done together keep busy
        pulse(1'b1, 1'b1, 1'b0);
        bus(1'b0, ad(IDX_STATUS), 32'h0, 1'b0);
        pulse(1'b0, 1'b1, 1'b1);
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        init_mem();
        @(posedge clk_sys);
        pulse(1'b0, 1'b0, 1'b1);
        rd_all();
        repeat (3) @(posedge clk_sys);
        if (qRd.size() + qEng.size() != 0) n_fail++;
        tally_and_finish();
    end
endmodule // testbench
